// ### design/pcp_pkg.sv
package pcp_pkg;

  // Register byte offsets inside one port group
  localparam logic [7:0] OFS_DIR = 8'h00;
  localparam logic [7:0] OFS_DIR_CLR = 8'h04;
  localparam logic [7:0] OFS_DIR_SET = 8'h08;
  localparam logic [7:0] OFS_DIR_TGL = 8'h0C;
  localparam logic [7:0] OFS_OUT = 8'h10;
  localparam logic [7:0] OFS_OUT_CLR = 8'h14;
  localparam logic [7:0] OFS_OUT_SET = 8'h18;
  localparam logic [7:0] OFS_OUT_TGL = 8'h1C;

  // Values after reset
  localparam logic [31:0] RST_DIR = 32'h0000_0000;
  localparam logic [31:0] RST_OUT = 32'h0000_0000;

  // Peripheral-bus delay on collision, in cycles
  localparam int PBUS_COLLIDE_DELAY = 1;

  // Write operation decoded from an alias offset
  typedef enum logic [1:0] {PCP_OP_WRITE, PCP_OP_CLR, PCP_OP_SET, PCP_OP_TGL}
    pcp_op_t;

  // One register access request
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcp_req_t;

  // Pad controls for one pin
  typedef struct packed {
    logic drive_en;
    logic drive_val;
    logic in_buf_en;
    logic pull_en;
    logic pull_up;
    logic dig_off;
  } pcp_pad_t;

endpackage : pcp_pkg

// ### design/pcp_pad_decode.sv
`timescale 1ns/100ps
// Combinational pad control decode for one pin
module pcp_pad_decode (
  // Pin settings
  input wire logic dir,
  input wire logic out_level,
  input wire logic input_buffer_on,
  input wire logic pull_resistor_on,
  // Pad control
  output pcp_pkg::pcp_pad_t pad
);

  // Driver wins over pull so the pad never fights itself
  always_comb
  begin
    pad.drive_en = dir;
    pad.drive_val = out_level;
    pad.in_buf_en = input_buffer_on;
    pad.pull_en = pull_resistor_on & ~dir;
    pad.pull_up = out_level;
    pad.dig_off = ~dir & ~input_buffer_on & ~pull_resistor_on;
  end

endmodule : pcp_pad_decode

// ### design/pcp_port.sv
`timescale 1ns/100ps
// How it works
// - all off gives analog, all digital disabled
// - pull direction follows output level bit
// - output direction drives push-pull per level
// - input without pull leaves pin floating
// - enabled driver forces pull off
// - each pin picks driver or pull itself
// - pull setup separate, no glitchy intermediate states
// - local bus wins, never stalled
// - pin level readable as input or output
// - no sampling while input buffer off
// - alias ones set, clear or toggle bits
// - colliding peripheral access waits until a cycle with the local bus idle
module pcp_port #(
  parameter int PINS = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // CPU local single-cycle bus
  input pcp_pkg::pcp_req_t cpu_local_port_bus,
  output logic [31:0] local_rdata,
  // Peripheral bus
  input pcp_pkg::pcp_req_t pbus,
  output logic pbus_ready,
  output logic [31:0] pbus_rdata,
  // Per-pin setup
  input wire logic [PINS-1:0] input_buffer_on,
  input wire logic [PINS-1:0] pull_resistor_on,
  // Pads
  input wire logic [PINS-1:0] pin_in,
  output pcp_pkg::pcp_pad_t [PINS-1:0] pad,
  output logic [PINS-1:0] pin_sampled
);

  initial
  begin
    if (PINS < 1 || PINS > 32)
      $error("PINS must be 1 to 32");
    // The held copy is served on the first cycle with the local bus idle, not after a set count
    if (pcp_pkg::PBUS_COLLIDE_DELAY != 1)
      $error("Collision delay other than one cycle is not supported");
  end

  // Port state and its next values
  logic [31:0] pin_direction_reg;
  logic [31:0] output_level_reg;
  logic [31:0] next_dir;
  logic [31:0] next_out;
  // Collided peripheral request, held until a cycle with the local bus idle
  logic pend;
  logic next_pend;
  pcp_pkg::pcp_req_t pend_req;
  pcp_pkg::pcp_req_t next_pend_req;
  pcp_pkg::pcp_req_t pb_act;
  logic [31:0] next_local_rdata;
  logic [31:0] next_pbus_rdata;
  logic [PINS-1:0] next_sampled;

  // Helpers for the read and the write decode; only mapped is used by both
  // Byte enables widened to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  // Apply one write or alias write to a register
  function automatic logic [31:0] apply(
    input logic [31:0] cur,
    input logic [1:0] op,
    input logic [31:0] m,
    input logic [31:0] d
  );
    // Plain write honours the byte lanes; aliases act on ones only
    unique case (op)
      2'h0: apply = (cur & ~m) | (d & m);
      2'h1: apply = cur & ~(d & m);
      2'h2: apply = cur | (d & m);
      default: apply = cur ^ (d & m);
    endcase
  endfunction : apply

  // Offset lies in the eight mapped words; anything else is refused
  function automatic logic mapped(input logic [7:0] a);
    mapped = a[7:5] == 3'h0 && a[1:0] == 2'h0;
  endfunction : mapped

  // Register read decode; aliases read back the underlying register
  function automatic logic [31:0] rd(
    input logic [7:0] a,
    input logic [31:0] d,
    input logic [31:0] o
  );
    if (!mapped(a))
      rd = 32'h0000_0000;
    else if (a[4])
      rd = o;
    else
      rd = d;
  endfunction : rd

  // One requester applied to the pair of registers
  function automatic logic [63:0] wr(
    input pcp_pkg::pcp_req_t r,
    input logic [31:0] d,
    input logic [31:0] o
  );
    logic [31:0] nd;
    logic [31:0] no;
    logic [1:0] op;
    nd = d;
    no = o;
    op = r.addr[3:2];
    // Level register sits in the upper half of the map
    if (r.valid && r.write && mapped(r.addr))
    begin
      if (r.addr[4])
        no = apply(o, op, be_mask(r.be), r.wdata);
      else
        nd = apply(d, op, be_mask(r.be), r.wdata);
    end
    wr = {nd, no};
  endfunction : wr

  // Peripheral access served now: held one, or new one when local idle
  // The local bus has no wait states, so it always takes the cycle;
  // ready low tells the master that the held copy is still owed
  always_comb
  begin
    pb_act = pend ? pend_req : pbus;
    if (cpu_local_port_bus.valid)
      pb_act.valid = 1'b0;
    pbus_ready = ~pend;
  end

  // Arbitration and register update
  // Local write lands first, a served peripheral write goes on top;
  // read data shows the registers as they were before this edge
  always_comb
  begin
    logic [63:0] s;
    s = 64'h0;
    next_pend = pend;
    next_pend_req = pend_req;
    next_pbus_rdata = pbus_rdata;
    s = wr(cpu_local_port_bus, pin_direction_reg, output_level_reg);
    next_local_rdata = rd(cpu_local_port_bus.addr, pin_direction_reg,
      output_level_reg);
    if (pb_act.valid)
    begin
      s = wr(pb_act, s[63:32], s[31:0]);
      next_pbus_rdata = rd(pb_act.addr, pin_direction_reg, output_level_reg);
      next_pend = 1'b0;
    end
    else if (!pend && pbus.valid)
    begin
      next_pend = 1'b1;
      next_pend_req = pbus;
    end
    next_dir = s[63:32];
    next_out = s[31:0];
  end

  // Input sampling gated per pin by its buffer enable
  // Pins with the buffer off keep their old sample, so a floating
  // pad never toggles the sampling flops
  always_comb
  begin
    next_sampled = (pin_sampled & ~input_buffer_on)
      | (pin_in & input_buffer_on);
  end

  // Register stage
  // With the setup at 0, reset leaves every pad analog
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pin_direction_reg <= pcp_pkg::RST_DIR;
      output_level_reg <= pcp_pkg::RST_OUT;
      pend <= 1'b0;
      pend_req <= '0;
      local_rdata <= 32'h0000_0000;
      pbus_rdata <= 32'h0000_0000;
      pin_sampled <= '0;
    end
    else
    begin
      pin_direction_reg <= next_dir;
      output_level_reg <= next_out;
      pend <= next_pend;
      pend_req <= next_pend_req;
      local_rdata <= next_local_rdata;
      pbus_rdata <= next_pbus_rdata;
      pin_sampled <= next_sampled;
    end
  end

  // Pad decode per pin; pull kept apart from direction and level
  // Driver enable masks the pull, so no direction change can show
  // a pad that is pulled and driven at once
  for (genvar i = 0; i < PINS; i++)
  begin : g_pin
    pcp_pad_decode u_dec (
      .dir(pin_direction_reg[i]),
      .out_level(output_level_reg[i]),
      .input_buffer_on(input_buffer_on[i]),
      .pull_resistor_on(pull_resistor_on[i]),
      .pad(pad[i])
    );
  end

endmodule : pcp_port

// ### sim/pcp_port_checker.sv
`timescale 1ns/100ps
module pcp_port_checker #(
  parameter int PINS = 32
) (
  // Clock, reset, buses
  input wire logic mclk,
  input wire logic rst_b,
  input pcp_pkg::pcp_req_t cpu_local_port_bus,
  input pcp_pkg::pcp_req_t pbus,
  input wire logic pbus_ready,
  // Pins
  input wire logic [PINS-1:0] input_buffer_on,
  input wire logic [PINS-1:0] pull_resistor_on,
  input wire logic [PINS-1:0] pin_in,
  input pcp_pkg::pcp_pad_t [PINS-1:0] pad,
  input wire logic [PINS-1:0] pin_sampled
);
  pcp_pkg::pcp_req_t l;
  pcp_pkg::pcp_pad_t p;
  logic w0;
  // Pin 0 stands for all, the decode is the same per pin
  assign l = cpu_local_port_bus;
  assign p = pad[0];
  assign w0 = l.valid && l.write && l.be[0] && l.wdata[0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_off;
    !p.drive_en && !input_buffer_on[0] && !pull_resistor_on[0]
      |-> p.dig_off && !p.pull_en && !p.in_buf_en;
  endproperty
  a_off: assert property (p_off) else $error("pad not off");
  property p_pul;
    pull_resistor_on[0] && !p.drive_en |-> p.pull_en;
  endproperty
  a_pul: assert property (p_pul) else $error("pull missing");
  property p_drv;
    p.drive_en |-> !p.dig_off && p.in_buf_en == input_buffer_on[0];
  endproperty
  a_drv: assert property (p_drv) else $error("bad drive");
  property p_np;
    p.drive_en |-> !p.pull_en;
  endproperty
  a_np: assert property (p_np) else $error("pull on drive");
  property p_dw;
    w0 && l.addr == pcp_pkg::OFS_DIR_SET |=> p.drive_en;
  endproperty
  a_dw: assert property (p_dw) else $error("dir set late");
  property p_set;
    w0 && l.addr == pcp_pkg::OFS_OUT_SET && p.drive_en |=> p.drive_val;
  endproperty
  a_set: assert property (p_set) else $error("out set");
  property p_col;
    l.valid && pbus.valid |=> !pbus_ready ##1 pbus_ready;
  endproperty
  a_col: assert property (p_col) else $error("collision");
  property p_smp;
    input_buffer_on[0] |=> pin_sampled[0] == $past(pin_in[0]);
  endproperty
  a_smp: assert property (p_smp) else $error("sample");
  c_col: cover property (l.valid && pbus.valid);
  c_drv: cover property (p.drive_en && p.drive_val);
  c_pul: cover property (p.pull_en && p.pull_up);
endmodule : pcp_port_checker
bind pcp_port pcp_port_checker #(.PINS(PINS)) CHK (.mclk, .rst_b,
  .cpu_local_port_bus, .pbus, .pbus_ready, .input_buffer_on,
  .pull_resistor_on, .pin_in, .pad, .pin_sampled);

// ### sim/pcp_pins.sv
`timescale 1ns/100ps
// Board side of the pins: nothing outside drives them
module pcp_pins (
  // Clock
  input wire logic mclk,
  // Pads
  input pcp_pkg::pcp_pad_t [31:0] pad,
  output logic [31:0] pin_in
);
  logic [31:0] last = 32'h0;
  // A floating pin flips every cycle so no settled level is trusted
  always @*
    for (int i = 0; i < 32; i++)
      pin_in[i] = pad[i].drive_en ? pad[i].drive_val
        : pad[i].pull_en ? pad[i].pull_up : ~last[i];
  // Last level, inverted while floating
  always @(posedge mclk)
    last <= pin_in;
endmodule : pcp_pins

// ### sim/tb_pcp_port.sv
`timescale 1ns/100ps
module tb_pcp_port;
  logic mclk = 0;
  logic rst_b = 0;
  pcp_pkg::pcp_req_t lb = '0;
  pcp_pkg::pcp_req_t pb = '0;
  logic [31:0] ib = 32'h0;
  logic [31:0] pu = 32'h0;
  logic [31:0] pin, lrd, smp, prd;
  logic rdy;
  pcp_pkg::pcp_pad_t [31:0] pad;
  int miscompares = 0;
  int checks_done = 0;
  // Device and the board around it
  pcp_port DUT (.mclk, .rst_b, .cpu_local_port_bus(lb), .local_rdata(lrd),
    .pbus(pb), .pbus_ready(rdy), .pbus_rdata(prd), .input_buffer_on(ib),
    .pull_resistor_on(pu), .pin_in(pin), .pad, .pin_sampled(smp));
  pcp_pins EXT (.mclk, .pad, .pin_in(pin));
  initial
    forever #25 mclk = ~mclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask : chk
  task automatic stop_test;
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic tk(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : tk
  // One local cycle; request stands until the next one replaces it
  task automatic la(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    lb = '{1'b1, w, a, 4'hF, d};
    tk(1);
  endtask : la
  // Plain write, clear, set, toggle on both registers
  task automatic t_alias;
    logic [7:0] b;
    logic [31:0] wd[4] = '{32'hF1, 32'h30, 32'h05, 32'h80};
    logic [31:0] ex[4] = '{32'hF1, 32'hC1, 32'hC5, 32'h45};
    for (int k = 0; k < 8; k++)
    begin
      b = k > 3 ? pcp_pkg::OFS_OUT : pcp_pkg::OFS_DIR;
      la(1, b + 8'(4 * (k % 4)), wd[k % 4]);
      la(0, b, 32'h0);
      chk(lrd, ex[k % 4]);
    end
  endtask : t_alias
  // Settings to pad controls, then input sampling
  task automatic t_pad;
    logic [3:0] cf[5] = '{4'h1, 4'h5, 4'h2, 4'hF, 4'hA};
    logic [3:0] ex[5] = '{4'h2, 4'h3, 4'h4, 4'hD, 4'hC};
    logic [3:0] s;
    for (int k = 0; k < 5; k++)
    begin
      la(1, pcp_pkg::OFS_DIR, 32'(cf[k][3]));
      la(1, pcp_pkg::OFS_OUT, 32'(cf[k][2]));
      ib[0] = cf[k][1];
      pu[0] = cf[k][0];
      #1;
      s = {pad[0].drive_en, pad[0].in_buf_en, pad[0].pull_en, pad[0].pull_up};
      chk(32'(s), 32'(ex[k]));
    end
    tk(1);
    chk(32'(smp[0]), 32'h0);
    ib[0] = 0;
    la(1, pcp_pkg::OFS_OUT, 32'h1);
    tk(2);
    chk(32'(smp[0]), 32'h0);
  endtask : t_pad
  // Both buses in one cycle: local first, peripheral a cycle on
  task automatic t_coll;
    int n;
    la(1, pcp_pkg::OFS_DIR, 32'h0);
    lb = '{1'b1, 1'b1, pcp_pkg::OFS_DIR_SET, 4'hF, 32'h1};
    pb = '{1'b1, 1'b1, pcp_pkg::OFS_OUT, 4'hF, 32'h0};
    tk(1);
    lb.valid = 0;
    pb.valid = 0;
    chk(32'(pad[0].drive_en), 32'h1);
    chk(32'(pad[0].drive_val), 32'h1);
    for (n = 0; n < 4 && rdy !== 1'b1; n++)
      tk(1);
    if (n == 4)
    begin
      miscompares++;
      stop_test();
    end
    chk(32'(n), 32'h1);
    chk(32'(pad[0].drive_val), 32'h0);
    pb = '{1'b1, 1'b0, pcp_pkg::OFS_DIR, 4'hF, 32'h0};
    tk(1);
    pb.valid = 0;
    chk(prd, 32'h1);
  endtask : t_coll
  initial
  begin
    repeat (6) @(posedge mclk);
    #1;
    rst_b = 1;
    chk(32'(pad[0]), 32'h01);
    la(0, 8'h20, 32'h0);
    chk(lrd, 32'h0);
    t_alias();
    t_pad();
    t_coll();
    stop_test();
  end
endmodule : tb_pcp_port
